// file: logic/synth_pkg.sv
/*
  Shared constants and types for the three-wire programmed synthesiser core.
  Assumes a 100 MHz system clock and a 4 MHz crystal arriving as a pin.
*/
// Contract
// - Serial bits enter the shift register only while enable is high.
// - Bus clock edges are ignored whenever enable is low.
// - Buffers take the shift register only on enable falling, else hold.
// - The divider is loaded with a 14- or 15-bit divisor from the word.
// - Feedback and comparison ticks are compared in phase and frequency.
// - The comparison frequency is the 4 MHz crystal divided down.
// - Step is 50 kHz at the lower and 62.5 kHz at the higher rate.
// - Lock output sinks when locked and floats while out of lock.
// - Four open-collector switch outputs follow four bits of the word.
// - Mode select high gives mode 1, low gives mode 2.
// - Both modes use the same crystal with a different division.
// - The serial word is 18 bits in mode 1 and 19 bits in mode 2.
package synth_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int XTAL_HZ       = 4_000_000;
  localparam int FCOMP_DIV_M1  = 512;   // 7.8125 kHz
  localparam int FCOMP_DIV_M2  = 640;   // 6.25 kHz
  localparam int LOCK_WIN_NS   = 1000;  // Largest phase error counted good
  localparam int LOCK_WIN_CYC  = (LOCK_WIN_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int LOCK_COUNT    = 4;     // Good comparisons before lock

  // ---------------------------------------------------------------------
  // Word format
  // ---------------------------------------------------------------------
  localparam int WORD_BITS_M1  = 18;
  localparam int WORD_BITS_M2  = 19;
  localparam int DIV_BITS      = 15;
  localparam int PORT_BITS     = 4;
  localparam int PORT_LSB      = 0;     // Ports are the last four bits
  localparam int DIV_LSB       = 4;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_MASK    = 4'h4;
  localparam logic [3:0] ADDR_CTRL    = 4'h8;
  localparam logic [3:0] ADDR_WORD    = 4'hC;
  localparam int ST_BITS        = 3;
  localparam int ST_LOADED      = 0;
  localparam int ST_LOCK_GAIN   = 1;
  localparam int ST_LOCK_LOST   = 2;
  localparam int CTRL_PUMP_EN   = 0;
  localparam int WORD_MODE_BIT  = 19;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET   = 3'h0;
  localparam logic [0:0] CTRL_RESET   = 1'h1;

  // Comparator states
  typedef enum logic [2:0] {
    PFD_IDLE = 3'b001,
    PFD_UP   = 3'b010,
    PFD_DOWN = 3'b100
  } pfd_state_t;

endpackage

// file: logic/phase_comparator.sv
/*
  Phase-frequency comparator with lock detection.
  Assumes ref_tick and fb_tick are one-cycle pulses on clock.
*/
`timescale 1ns/100ps
module phase_comparator (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic ref_tick,
  input  wire logic fb_tick,
  input  wire logic pump_enable,
  output logic      pump_up,
  output logic      pump_down,
  output logic      locked
);

  synth_pkg::pfd_state_t state_reg, state_next;
  logic [7:0] err_reg, err_next;
  logic [2:0] good_reg, good_next;
  logic       locked_next, up_next, down_next;
  logic       done, good;

  // ---------------------------------------------------------------------
  // Next state: lead of one tick over the other drives the pump
  // ---------------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    err_next    = err_reg;
    good_next   = good_reg;
    locked_next = locked;
    done        = 1'b0;
    good        = 1'b0;
    unique case (state_reg)
      synth_pkg::PFD_IDLE: begin
        err_next = 8'h00;
        if (ref_tick && fb_tick) begin
          done = 1'b1;
          good = 1'b1;
        end else if (ref_tick) begin
          state_next = synth_pkg::PFD_UP;
        end else if (fb_tick) begin
          state_next = synth_pkg::PFD_DOWN;
        end
      end
      synth_pkg::PFD_UP, synth_pkg::PFD_DOWN: begin
        if (err_reg != 8'hFF) begin
          err_next = err_reg + 8'h01;
        end
        // A second tick of the same kind is a slip in frequency
        if ((state_reg == synth_pkg::PFD_UP) ? ref_tick : fb_tick) begin
          done = 1'b1;
        end
        if ((state_reg == synth_pkg::PFD_UP) ? fb_tick : ref_tick) begin
          done       = 1'b1;
          good       = (err_reg < 8'(synth_pkg::LOCK_WIN_CYC));
          state_next = synth_pkg::PFD_IDLE;
        end
      end
      default: state_next = synth_pkg::PFD_IDLE;
    endcase
    // Lock needs a run of good comparisons, one bad one drops it
    if (done) begin
      if (!good) begin
        good_next   = 3'h0;
        locked_next = 1'b0;
      end else if (good_reg == 3'(synth_pkg::LOCK_COUNT - 1)) begin
        locked_next = 1'b1;
      end else begin
        good_next = good_reg + 3'h1;
      end
    end
    up_next   = pump_enable && (state_next == synth_pkg::PFD_UP);
    down_next = pump_enable && (state_next == synth_pkg::PFD_DOWN);
  end

  // Register the comparator
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= synth_pkg::PFD_IDLE;
      err_reg   <= 8'h00;
      good_reg  <= 3'h0;
      locked    <= 1'b0;
      pump_up   <= 1'b0;
      pump_down <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      err_reg   <= err_next;
      good_reg  <= good_next;
      locked    <= locked_next;
      pump_up   <= up_next;
      pump_down <= down_next;
    end
  end

endmodule // phase_comparator

// file: logic/synth_control.sv
/*
  Digital core of a three-wire programmed PLL synthesiser: serial word
  capture, reference and programmable dividers, comparator, lock flag,
  switch outputs and a small register port with interrupt.
  Assumes bus pins, crystal and divided RF arrive asynchronously and are
  far slower than clock (crystal 4 MHz, bus clock 8 MHz or less).
*/
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module synth_control #(
  parameter int DIV_W  = synth_pkg::DIV_BITS,
  parameter int PORT_W = synth_pkg::PORT_BITS
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic              bus_data,
  input  wire logic              bus_clk,
  input  wire logic              bus_enable,
  input  wire logic              mode_sel,
  input  wire logic              xtal_in,
  input  wire logic              divided_feedback_freq,
  input  wire logic [3:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  output logic                   irq,
  output logic                   pump_up,
  output logic                   pump_down,
  output logic                   lock_out,
  output logic                   lock_oe_b,
  output logic      [PORT_W-1:0] switch_outputs,
  output logic      [PORT_W-1:0] switch_oe_b
);

  localparam int WORD_W = DIV_W + PORT_W;
  localparam int NSYNC  = 6;

  // ---------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------
  logic [NSYNC-1:0] pins, sync1_reg, sync2_reg, prev_reg;
  logic             data_s, clk_s, en_s, mode_s, xtal_s, fb_s;
  logic             clk_rise, en_fall, xtal_rise, fb_rise;

  assign pins = {divided_feedback_freq, xtal_in, mode_sel,
                 bus_enable, bus_clk, bus_data};

  // Two stages per pin, then a third copy for edge detection
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          prev_reg[gi]  <= 1'b0;
        end else if (ce) begin
          sync1_reg[gi] <= pins[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          prev_reg[gi]  <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  assign data_s    = sync2_reg[0];
  assign clk_s     = sync2_reg[1];
  assign en_s      = sync2_reg[2];
  assign mode_s    = sync2_reg[3];
  assign xtal_s    = sync2_reg[4];
  assign fb_s      = sync2_reg[5];
  assign clk_rise  = clk_s && !prev_reg[1];
  assign en_fall   = !en_s && prev_reg[2];
  assign xtal_rise = xtal_s && !prev_reg[4];
  assign fb_rise   = fb_s && !prev_reg[5];

  // ---------------------------------------------------------------------
  // Serial word capture and buffers
  // ---------------------------------------------------------------------
  logic [WORD_W-1:0] shift_reg, shift_next;
  logic [DIV_W-1:0]  divisor_reg, divisor_next;
  logic [PORT_W-1:0] ports_reg, ports_next;
  logic              loaded;

  // Data is synchronised with the same delay as the bus clock, so the
  // bit seen at the clock edge is the one set up before it
  always_comb begin
    shift_next   = shift_reg;
    divisor_next = divisor_reg;
    ports_next   = ports_reg;
    loaded       = 1'b0;
    if (en_s && clk_rise) begin
      shift_next = {shift_reg[WORD_W-2:0], data_s};
    end
    if (en_fall) begin
      loaded     = 1'b1;
      ports_next = shift_reg[synth_pkg::PORT_LSB +: PORT_W];
      // Mode 1 words are one bit short: the divisor MSB is bypassed
      if (mode_s) begin
        divisor_next = {1'b0, shift_reg[synth_pkg::DIV_LSB +: DIV_W-1]};
      end else begin
        divisor_next = shift_reg[synth_pkg::DIV_LSB +: DIV_W];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg   <= '0;
      divisor_reg <= '0;
      ports_reg   <= '0;
    end else if (ce) begin
      shift_reg   <= shift_next;
      divisor_reg <= divisor_next;
      ports_reg   <= ports_next;
    end
  end

  // ---------------------------------------------------------------------
  // Reference divider: crystal down to the comparison frequency
  // ---------------------------------------------------------------------
  logic [9:0] ref_cnt_reg, ref_cnt_next, ref_last;
  logic       ref_tick_reg, ref_tick_next;

  always_comb begin
    // Mode 1 gives 7.8125 kHz, mode 2 gives 6.25 kHz from one crystal
    ref_last = mode_s ? 10'(synth_pkg::FCOMP_DIV_M1 - 1)
                      : 10'(synth_pkg::FCOMP_DIV_M2 - 1);
    ref_cnt_next  = ref_cnt_reg;
    ref_tick_next = 1'b0;
    if (xtal_rise) begin
      if (ref_cnt_reg >= ref_last) begin
        ref_cnt_next  = 10'h000;
        ref_tick_next = 1'b1;
      end else begin
        ref_cnt_next = ref_cnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt_reg  <= 10'h000;
      ref_tick_reg <= 1'b0;
    end else if (ce) begin
      ref_cnt_reg  <= ref_cnt_next;
      ref_tick_reg <= ref_tick_next;
    end
  end

  // ---------------------------------------------------------------------
  // Programmable divider on the prescaled RF; with the prescaler by 8
  // outside, one count is 8 times the comparison rate: 50 or 62.5 kHz
  // ---------------------------------------------------------------------
  logic [DIV_W-1:0] prog_cnt_reg, prog_cnt_next, reload_val;
  logic             fb_tick_reg, fb_tick_next;

  // A divisor of 0 or 1 would tick on every edge; floor it at 2 so the
  // comparator never sees feedback faster than half the prescaled input
  assign reload_val = (divisor_reg < DIV_W'(2)) ? DIV_W'(2) : divisor_reg;

  always_comb begin
    prog_cnt_next = prog_cnt_reg;
    fb_tick_next  = 1'b0;
    if (fb_rise) begin
      // Reload on terminal count
      if (prog_cnt_reg <= DIV_W'(1)) begin
        prog_cnt_next = reload_val;
        fb_tick_next  = 1'b1;
      end else begin
        prog_cnt_next = prog_cnt_reg - DIV_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prog_cnt_reg <= '0;
      fb_tick_reg  <= 1'b0;
    end else if (ce) begin
      prog_cnt_reg <= prog_cnt_next;
      fb_tick_reg  <= fb_tick_next;
    end
  end

  // ---------------------------------------------------------------------
  // Comparator and lock
  // ---------------------------------------------------------------------
  logic ctrl_reg, ctrl_next;
  logic locked, locked_prev_reg;

  phase_comparator u_cmp (
    .clock       (clock),
    .rst_b       (rst_b),
    .ce          (ce),
    .ref_tick    (ref_tick_reg),
    .fb_tick     (fb_tick_reg),
    .pump_enable (ctrl_reg),
    .pump_up     (pump_up),
    .pump_down   (pump_down),
    .locked      (locked)
  );

  // ---------------------------------------------------------------------
  // Register port and interrupt
  // ---------------------------------------------------------------------
  logic [synth_pkg::ST_BITS-1:0] status_reg, status_next, set_bits;
  logic [synth_pkg::ST_BITS-1:0] mask_reg, mask_next;
  logic [31:0]                   rdata_next;
  logic [3:0]                    reg_sel;
  logic                          irq_next;

  // One-hot select shared by the write and read paths, so the set of
  // offsets that exist can never differ between the two
  function automatic logic [3:0] reg_select(input logic [3:0] a);
    logic [3:0] sel;
    sel = 4'h0;
    unique case (a)
      synth_pkg::ADDR_STATUS: sel[0] = 1'b1;
      synth_pkg::ADDR_MASK:   sel[1] = 1'b1;
      synth_pkg::ADDR_CTRL:   sel[2] = 1'b1;
      synth_pkg::ADDR_WORD:   sel[3] = 1'b1;
      default:                sel    = 4'h0;
    endcase
    return sel;
  endfunction

  // Hardware sets win over a write-one clear in the same cycle
  always_comb begin
    reg_sel  = reg_select(addr);
    set_bits = '0;
    set_bits[synth_pkg::ST_LOADED]    = loaded;
    set_bits[synth_pkg::ST_LOCK_GAIN] = locked && !locked_prev_reg;
    set_bits[synth_pkg::ST_LOCK_LOST] = !locked && locked_prev_reg;
    status_next = status_reg;
    mask_next   = mask_reg;
    ctrl_next   = ctrl_reg;
    // The word register is read-only: a write to it falls through
    if (wr && reg_sel[0]) begin
      status_next = status_reg & ~wdata[synth_pkg::ST_BITS-1:0];
    end
    if (wr && reg_sel[1]) begin
      mask_next = wdata[synth_pkg::ST_BITS-1:0];
    end
    if (wr && reg_sel[2]) begin
      ctrl_next = wdata[synth_pkg::CTRL_PUMP_EN];
    end
    status_next = status_next | set_bits;
    irq_next    = |(status_next & mask_next);
    // Unmapped reads return zero rather than a stale word
    rdata_next  = 32'h0000_0000;
    if (rd && reg_sel[0]) begin
      rdata_next[synth_pkg::ST_BITS-1:0] = status_reg;
    end
    if (rd && reg_sel[1]) begin
      rdata_next[synth_pkg::ST_BITS-1:0] = mask_reg;
    end
    if (rd && reg_sel[2]) begin
      rdata_next[synth_pkg::CTRL_PUMP_EN] = ctrl_reg;
    end
    if (rd && reg_sel[3]) begin
      rdata_next[WORD_W-1:0] = {divisor_reg, ports_reg};
      rdata_next[synth_pkg::WORD_MODE_BIT] = mode_s;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status_reg      <= synth_pkg::STATUS_RESET;
      mask_reg        <= synth_pkg::MASK_RESET;
      ctrl_reg        <= synth_pkg::CTRL_RESET;
      locked_prev_reg <= 1'b0;
      rdata           <= 32'h0000_0000;
      irq             <= 1'b0;
    end else if (ce) begin
      status_reg      <= status_next;
      mask_reg        <= mask_next;
      ctrl_reg        <= ctrl_next;
      locked_prev_reg <= locked;
      rdata           <= rdata_next;
      irq             <= irq_next;
    end
  end

  // ---------------------------------------------------------------------
  // Open-collector outputs: a set bit sinks, a clear bit floats
  // ---------------------------------------------------------------------
  // The value lines stay low and only the enables move, so a pin can
  // never be driven high against its external pull-up
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lock_out       <= 1'b0;
      lock_oe_b      <= 1'b1;
      switch_outputs <= '0;
      switch_oe_b    <= '1;
    end else if (ce) begin
      lock_out       <= 1'b0;
      lock_oe_b      <= !locked;
      switch_outputs <= '0;
      switch_oe_b    <= ~ports_reg;
    end
  end

endmodule // synth_control

// file: tb/synth_control_chk.sv
/*
  Port assertions for the synthesiser core: register port, load timing,
  open-drain outputs and comparator outputs.
  Assumes a single clock domain; bound to every synth_control instance.
*/
`timescale 1ns/100ps
module synth_control_chk #(
  parameter int PORT_W = 4
) (
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic              ce,
  input wire logic              bus_enable,
  input wire logic [3:0]        addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [31:0]       rdata,
  input wire logic              irq,
  input wire logic              pump_up,
  input wire logic              pump_down,
  input wire logic              lock_out,
  input wire logic [PORT_W-1:0] switch_outputs,
  input wire logic [PORT_W-1:0] switch_oe_b
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Read data only stands in the cycle after a read
  chk_rdata_idle: assert property ((ce && !rd) |=> rdata == 32'h0)
    else $error("rdata not zero outside a read");
  chk_unmapped_read: assert property ((ce && rd && addr[1:0] != 2'h0)
    |=> rdata == 32'h0) else $error("unmapped read not zero");
  chk_mask_readback: assert property ((ce && rd
    && addr == synth_pkg::ADDR_MASK && $past(wr, 2)
    && $past(addr, 2) == synth_pkg::ADDR_MASK)
    |=> rdata[2:0] == $past(wdata[2:0], 3))
    else $error("mask read differs from write");
  chk_irq_masked: assert property ((ce && wr && wdata[2:0] == 3'h0
    && addr == synth_pkg::ADDR_MASK) |=> !irq)
    else $error("irq high with all masked");
  // Open-drain pins only ever sink
  chk_lock_open_drain: assert property (lock_out == 1'b0)
    else $error("lock output driven high");
  chk_port_open_drain: assert property (switch_outputs == '0)
    else $error("switch output driven high");
  // Switch outputs move only after enable has fallen, never during a frame
  chk_ports_on_load: assert property ($changed(switch_oe_b)
    |-> !bus_enable && !$past(bus_enable, 2))
    else $error("switch outputs changed outside a load");
  chk_ports_hold: assert property (bus_enable [*8]
    |-> $stable(switch_oe_b)) else $error("switch outputs moved in frame");
  chk_pump_exclusive: assert property (!(pump_up && pump_down))
    else $error("both pump outputs active");
  chk_pump_disabled: assert property ((ce && wr && !wdata[0]
    && addr == synth_pkg::ADDR_CTRL) |-> ##3 !(pump_up || pump_down))
    else $error("pump active while disabled");

  cover property ($rose(irq));
  cover property ($changed(switch_oe_b));
  cover property ($rose(pump_up));
  cover property ($rose(pump_down));
endmodule // synth_control_chk

bind synth_control synth_control_chk #(.PORT_W(PORT_W)) u_chk (
  .clock(clock), .rst_b(rst_b), .ce(ce), .bus_enable(bus_enable),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .irq(irq), .pump_up(pump_up), .pump_down(pump_down),
  .lock_out(lock_out), .switch_outputs(switch_outputs),
  .switch_oe_b(switch_oe_b)
);

// file: tb/serial_host.sv
/*
  Model of the controlling processor on the three-wire serial bus.
  Assumes the bench calls its tasks; pins are unrelated to the core clock.
*/
`timescale 1ns/100ps
module serial_host (
  output logic bus_data,
  output logic bus_clk,
  output logic bus_enable
);
  localparam real HALF = 62.5;  // 125 ns link clock period

  initial begin
    bus_data = 1'b0;
    bus_clk = 1'b0;
    bus_enable = 1'b0;
  end

  // One word per frame, MSB first; clock idles low between frames
  task automatic send(input logic [18:0] w, input int n, input bit drop);
    bus_enable = 1'b1;
    #300;
    for (int i = n - 1; i >= 0; i--) begin
      bus_data = w[i];
      #HALF bus_clk = 1'b1;
      #HALF bus_clk = 1'b0;
    end
    bus_data = ~bus_data;  // Released line must not keep the last bit
    #300;
    if (drop) finish_frame();
  endtask

  // Falling enable requests the load; wait long enough for it to land
  task automatic finish_frame();
    bus_enable = 1'b0;
    #1000;
  endtask

  // Deliberate clock pulses with enable low, data moving
  task automatic stray(input int n);
    repeat (n) begin
      bus_data = ~bus_data;
      #HALF bus_clk = 1'b1;
      #HALF bus_clk = 1'b0;
    end
  endtask
endmodule // serial_host

// file: tb/tb_synth_control.sv
/*
  Self-checking bench for the synthesiser core: serial loads in both
  modes, register port, interrupt and comparator outputs.
  Assumes serial_host as the processor and a 4 MHz crystal from here.
*/
`timescale 1ns/100ps
module tb_synth_control;
  logic        clock, rst_b, ce, mode_sel, xtal_in, fb, fb_on, wr, rd;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata;
  logic        irq, pump_up, pump_down, lock_out, lock_oe_b;
  logic [3:0]  sw_out, sw_oe_b;
  wire         bus_data, bus_clk, bus_enable;
  int          miscompares, num_checks, k;

  always #5 clock = ~clock;
  always #125 xtal_in = ~xtal_in;  // 4 MHz crystal
  always #125 fb = fb_on ? ~fb : fb;  // Fast feedback once switched on

  serial_host u_host (.bus_data(bus_data), .bus_clk(bus_clk),
    .bus_enable(bus_enable));

  synth_control u_dut (.clock(clock), .rst_b(rst_b), .ce(ce),
    .bus_data(bus_data), .bus_clk(bus_clk), .bus_enable(bus_enable),
    .mode_sel(mode_sel), .xtal_in(xtal_in), .divided_feedback_freq(fb),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .pump_up(pump_up), .pump_down(pump_down),
    .lock_out(lock_out), .lock_oe_b(lock_oe_b), .switch_outputs(sw_out),
    .switch_oe_b(sw_oe_b));

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobes last one cycle; each call starts on a fresh edge
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic expect_reg(input string what, input logic [3:0] a,
                            input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check(what, exp, rdata);
  endtask

  task automatic test_done();
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run is about 13k cycles, 23k if both waits run out; cut at 40k
  initial begin
    #400_000;
    miscompares++;
    test_done();
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    {clock, rst_b, wr, rd, mode_sel, xtal_in, fb, fb_on} = '0;
    ce = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    expect_reg("status", synth_pkg::ADDR_STATUS, 32'h0);
    expect_reg("mask", synth_pkg::ADDR_MASK, 32'h0);
    expect_reg("ctrl", synth_pkg::ADDR_CTRL, 32'h1);
    check("ports", 32'hF, {28'h0, sw_oe_b});
    check("lock", 32'h1, {31'h0, lock_oe_b});
    // Mode 2: 15-bit divisor then ports; buffers wait for enable fall
    u_host.send(19'h4B2D9, 19, 1'b0);
    expect_reg("word held", synth_pkg::ADDR_WORD, 32'h0);
    u_host.finish_frame();
    expect_reg("word", synth_pkg::ADDR_WORD, 32'h0004B2D9);
    check("ports", 32'h6, {28'h0, sw_oe_b});
    expect_reg("loaded", synth_pkg::ADDR_STATUS, 32'h1);
    // Clocks with enable low must not shift; an empty frame reloads
    u_host.stray(8);
    u_host.send(19'h0, 0, 1'b1);
    expect_reg("word kept", synth_pkg::ADDR_WORD, 32'h0004B2D9);
    // Interrupt: unmask, clear, unmapped and read-only places
    reg_wr(synth_pkg::ADDR_MASK, 32'h7);
    #1 check("irq set", 32'h1, {31'h0, irq});
    expect_reg("mask", synth_pkg::ADDR_MASK, 32'h7);
    reg_wr(synth_pkg::ADDR_STATUS, 32'h1);
    #1 check("irq clr", 32'h0, {31'h0, irq});
    expect_reg("status", synth_pkg::ADDR_STATUS, 32'h0);
    reg_wr(4'h2, 32'hFFFF_FFFF);
    expect_reg("unmapped", 4'h2, 32'h0);
    reg_wr(synth_pkg::ADDR_WORD, 32'h0);
    expect_reg("word ro", synth_pkg::ADDR_WORD, 32'h0004B2D9);
    // Mode 1: 18-bit word, divisor 3, ports 3
    mode_sel <= 1'b1;
    u_host.send(19'h00033, 18, 1'b1);
    expect_reg("word m1", synth_pkg::ADDR_WORD, 32'h00080033);
    check("ports m1", 32'hC, {28'h0, sw_oe_b});
    check("sinks", 32'h0, {27'h0, lock_out, sw_out});
    check("irq load", 32'h1, {31'h0, irq});
    reg_wr(synth_pkg::ADDR_MASK, 32'h0);
    #1 check("irq mask", 32'h0, {31'h0, irq});
    // No feedback: reference leads, so the loop must pump up
    for (k = 0; k < 20000 && pump_up !== 1'b1; k++) @(posedge clock);
    check("pump up", 32'h1, {31'h0, pump_up});
    fb_on <= 1'b1;
    for (k = 0; k < 2000 && pump_down !== 1'b1; k++) @(posedge clock);
    check("pump down", 32'h1, {31'h0, pump_down});
    check("unlocked", 32'h1, {31'h0, lock_oe_b});
    reg_wr(synth_pkg::ADDR_CTRL, 32'h0);
    repeat (4) @(posedge clock);
    check("pumps off", 32'h0, {30'h0, pump_up, pump_down});
    test_done();
  end
endmodule // tb_synth_control
